// file: rtl/flash_id_defs.svh
`ifndef FLASH_ID_DEFS_SVH
`define FLASH_ID_DEFS_SVH

// opcodes handled by this block
`define OPC_DUAL_ID 8'h92
`define OPC_QUAD_ID 8'h94
`define OPC_UNIQUE_ID 8'h4B
`define OPC_JEDEC_ID 8'h9F
`define OPC_PARAM_TABLE 8'h5A
`define OPC_SEC_ERASE 8'h44
`define OPC_SEC_PROG 8'h42

// serial clocks between the opcode and the first output edge or data byte
`define HDR_DUAL_ID 8'h10
`define HDR_QUAD_ID 8'h0C
`define HDR_UNIQUE_ID 8'h20
`define HDR_PARAM_TABLE 8'h20
`define HDR_SEC 8'h18
`define ADDR_BITS 8'h18

// output pattern lengths in bits
`define LEN_JEDEC 7'h18
`define LEN_MAKER_DEV 7'h10
`define LEN_UNIQUE 7'h40
`define LEN_BYTE 7'h08

// security register address fields
`define SEC_ADDR_HI 8'h00
`define SEC_ADDR_LOW_NIB 4'h0
`define SEC_SEL_FIRST 4'h1
`define SEC_SEL_LAST 4'h3

// self-timed cycle lengths
`define CLK_FREQ_MHZ 25
`define SEC_ERASE_TIME_US 1000
`define SEC_PROG_TIME_US 200

`endif

// file: rtl/flash_id_pkg.sv
package flash_id_pkg;

  // progress of one chip-select frame
  typedef enum logic [2:0] {
    ST_OPC,
    ST_HDR,
    ST_TX,
    ST_DATA,
    ST_DONE
  } frame_state_e;

  // self-timed array operation
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_PROG
  } op_state_e;

  // number of data lines used while shifting out
  typedef enum logic [1:0] {
    LANE_SINGLE,
    LANE_DUAL,
    LANE_QUAD
  } lane_mode_e;

endpackage

// file: rtl/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [PW:0] count_r, count_nxt;
  logic push, pop;

  // handshakes; full stalls the writer, empty holds off the reader
  // fill level is one bit wider than the pointers, so DEPTH itself fits
  assign in_ready_o = (count_r != (PW + 1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and fill-level update, wrapping at DEPTH
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage carries no reset; contents are only read while valid
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// file: rtl/flash_id_and_security_reg_cmds.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_defs.svh"

module flash_id_and_security_reg_cmds #(
  parameter logic [7:0] MAKER_ID = 8'h5C, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h17, // arbitrary value
  parameter logic [7:0] MEMORY_TYPE_BYTE = 8'h60, // arbitrary value
  parameter logic [7:0] CAPACITY_BYTE = 8'h18, // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // arbitrary value
  parameter int unsigned SEC_ERASE_CYCLES = `SEC_ERASE_TIME_US * `CLK_FREQ_MHZ,
  parameter int unsigned SEC_PROG_CYCLES = `SEC_PROG_TIME_US * `CLK_FREQ_MHZ
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic write_enable_latch_i,
  input wire logic [2:0] otp_lock_bits_i,
  output logic busy_o,
  output logic write_enable_clear_o,
  output logic erase_req_o,
  output logic [1:0] erase_sel_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [1:0] wr_sel_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] sfdp_addr_o,
  input wire logic [7:0] sfdp_data_i,
  output logic prog_overrun_o
);

  // pin synchronisers; stage one feeds only stage two
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic [3:0] io_s1_r, io_s2_r;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sclk_s1_r <= sclk_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
    end
  end

  // edge events seen on the system clock
  logic cs_low, cs_rise, sclk_rise, sclk_fall;
  assign cs_low = !cs_s2_r;
  assign cs_rise = cs_s2_r && !cs_s3_r;
  assign sclk_rise = sclk_s2_r && !sclk_s3_r;
  assign sclk_fall = !sclk_s2_r && sclk_s3_r;

  // frame decoder state
  flash_id_pkg::frame_state_e st_r, st_nxt;
  logic [7:0] opcode_r, opcode_nxt, byte_r, byte_nxt, cnt_r, cnt_nxt, hdr_len;
  logic [23:0] addr_r, addr_nxt, full_addr;
  logic [2:0] bitn_r, bitn_nxt;
  logic [7:0] pbyte_r, pbyte_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic accept_r, accept_nxt, extra_r, extra_nxt, has_byte_r, has_byte_nxt;
  logic ovr_r, ovr_nxt;
  logic [3:0] sel_field;
  logic sec_ok, push, buf_in_ready, buf_out_valid, erase_go, prog_go;
  logic [7:0] shifted_byte;
  logic busy_r;

  // header length after the opcode, per command
  always_comb begin
    case (opcode_r)
      `OPC_DUAL_ID: hdr_len = `HDR_DUAL_ID;
      `OPC_QUAD_ID: hdr_len = `HDR_QUAD_ID;
      `OPC_UNIQUE_ID: hdr_len = `HDR_UNIQUE_ID;
      `OPC_PARAM_TABLE: hdr_len = `HDR_PARAM_TABLE;
      default: hdr_len = `HDR_SEC;
    endcase
  end

  // address as it stands after this rising edge, and register checks
  assign full_addr = {addr_r[22:0], io_s2_r[0]};
  assign sel_field = full_addr[15:12];
  assign shifted_byte = {byte_r[6:0], io_s2_r[0]};
  always_comb begin
    sec_ok = (full_addr[23:16] == `SEC_ADDR_HI) && (full_addr[11:8] == `SEC_ADDR_LOW_NIB) &&
             (sel_field >= `SEC_SEL_FIRST) && (sel_field <= `SEC_SEL_LAST);
    if (sec_ok) begin
      sec_ok = !otp_lock_bits_i[sel_field[1:0] - 2'h1];
    end
    sec_ok = sec_ok && write_enable_latch_i;
  end

  // frame decoder: opcode, header, data bytes
  always_comb begin
    st_nxt = st_r;
    opcode_nxt = opcode_r;
    byte_nxt = byte_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    bitn_nxt = bitn_r;
    pbyte_nxt = pbyte_r;
    sel_nxt = sel_r;
    accept_nxt = accept_r;
    extra_nxt = extra_r;
    has_byte_nxt = has_byte_r;
    ovr_nxt = ovr_r;
    push = 1'b0;
    if (!cs_low) begin
      st_nxt = flash_id_pkg::ST_OPC;
      cnt_nxt = 8'h00;
      bitn_nxt = 3'h0;
      accept_nxt = 1'b0;
      extra_nxt = 1'b0;
      has_byte_nxt = 1'b0;
    end else if (sclk_rise) begin
      case (st_r)
        flash_id_pkg::ST_OPC: begin
          byte_nxt = shifted_byte;
          bitn_nxt = bitn_r + 3'h1;
          if (bitn_r == 3'h7) begin
            opcode_nxt = shifted_byte;
            ovr_nxt = 1'b0;
            if (busy_r) begin
              st_nxt = flash_id_pkg::ST_DONE; // no new command while the array is busy
            end else if (shifted_byte == `OPC_JEDEC_ID) begin
              st_nxt = flash_id_pkg::ST_TX;
            end else if (shifted_byte == `OPC_DUAL_ID || shifted_byte == `OPC_QUAD_ID ||
                         shifted_byte == `OPC_UNIQUE_ID || shifted_byte == `OPC_PARAM_TABLE ||
                         shifted_byte == `OPC_SEC_ERASE || shifted_byte == `OPC_SEC_PROG) begin
              st_nxt = flash_id_pkg::ST_HDR;
            end else begin
              st_nxt = flash_id_pkg::ST_DONE;
            end
          end
        end
        flash_id_pkg::ST_HDR: begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r < `ADDR_BITS) begin
            addr_nxt = full_addr;
          end
          if (cnt_nxt == hdr_len) begin
            if (opcode_r == `OPC_SEC_ERASE) begin
              st_nxt = flash_id_pkg::ST_DONE;
              accept_nxt = sec_ok;
              sel_nxt = sel_field[1:0];
            end else if (opcode_r == `OPC_SEC_PROG) begin
              st_nxt = flash_id_pkg::ST_DATA;
              accept_nxt = sec_ok;
              sel_nxt = sel_field[1:0];
              pbyte_nxt = full_addr[7:0];
            end else begin
              st_nxt = flash_id_pkg::ST_TX;
            end
          end
        end
        flash_id_pkg::ST_DATA: begin
          byte_nxt = shifted_byte;
          bitn_nxt = bitn_r + 3'h1;
          if (bitn_r == 3'h7 && accept_r) begin
            push = 1'b1;
            has_byte_nxt = 1'b1;
            pbyte_nxt = pbyte_r + 8'h01; // wraps inside the 256-byte register
            if (!buf_in_ready) begin
              ovr_nxt = 1'b1; // array port too slow; byte lost, flagged
            end
          end
        end
        default: begin
          extra_nxt = 1'b1; // any clock past the address spoils an erase
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= flash_id_pkg::ST_OPC;
      opcode_r <= 8'h00;
      byte_r <= 8'h00;
      cnt_r <= 8'h00;
      addr_r <= 24'h00_0000;
      bitn_r <= 3'h0;
      pbyte_r <= 8'h00;
      sel_r <= 2'h0;
      accept_r <= 1'b0;
      extra_r <= 1'b0;
      has_byte_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      opcode_r <= opcode_nxt;
      byte_r <= byte_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      bitn_r <= bitn_nxt;
      pbyte_r <= pbyte_nxt;
      sel_r <= sel_nxt;
      accept_r <= accept_nxt;
      extra_r <= extra_nxt;
      has_byte_r <= has_byte_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  // commit points, taken when chip select rises
  assign erase_go = cs_rise && opcode_r == `OPC_SEC_ERASE && st_r == flash_id_pkg::ST_DONE &&
                    accept_r && !extra_r;
  assign prog_go = cs_rise && opcode_r == `OPC_SEC_PROG && st_r == flash_id_pkg::ST_DATA &&
                   accept_r && has_byte_r;

  // program bytes wait here until the array write port takes them
  logic [17:0] buf_out_data;
  two_entry_buffer #(
    .WIDTH(18),
    .DEPTH(2)
  ) u_prog_buf (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .in_data_i({sel_r, pbyte_r, shifted_byte}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(wr_ready_i),
    .out_data_o(buf_out_data)
  );
  assign wr_valid_o = buf_out_valid;
  assign {wr_sel_o, wr_addr_o, wr_data_o} = buf_out_data;
  assign prog_overrun_o = ovr_r;

  // output shifter; the host samples on rising edges, so update on falling ones
  flash_id_pkg::lane_mode_e lane;
  logic [63:0] tx_sr_r, tx_sr_nxt, fresh, src;
  logic [6:0] tx_left_r, tx_left_nxt, fresh_len;
  logic [3:0] io_r, io_nxt, oe_r, oe_nxt, oe_mask;
  logic [7:0] sfdp_addr_r, sfdp_addr_nxt;

  always_comb begin
    case (opcode_r)
      `OPC_DUAL_ID: begin
        lane = flash_id_pkg::LANE_DUAL;
        oe_mask = 4'h3;
      end
      `OPC_QUAD_ID: begin
        lane = flash_id_pkg::LANE_QUAD;
        oe_mask = 4'hF;
      end
      default: begin
        lane = flash_id_pkg::LANE_SINGLE;
        oe_mask = 4'h2;
      end
    endcase
    case (opcode_r)
      `OPC_JEDEC_ID: begin
        fresh = {MAKER_ID, MEMORY_TYPE_BYTE, CAPACITY_BYTE, 40'h00_0000_0000};
        fresh_len = `LEN_JEDEC;
      end
      `OPC_UNIQUE_ID: begin
        fresh = UNIQUE_ID;
        fresh_len = `LEN_UNIQUE;
      end
      `OPC_PARAM_TABLE: begin
        fresh = {sfdp_data_i, 56'h00_0000_0000_0000};
        fresh_len = `LEN_BYTE;
      end
      default: begin
        fresh = {MAKER_ID, DEVICE_ID, 48'h0000_0000_0000};
        fresh_len = `LEN_MAKER_DEV;
      end
    endcase
  end

  always_comb begin
    tx_sr_nxt = tx_sr_r;
    tx_left_nxt = tx_left_r;
    io_nxt = io_r;
    oe_nxt = oe_r;
    sfdp_addr_nxt = sfdp_addr_r;
    src = (tx_left_r == 7'h00) ? fresh : tx_sr_r;
    if (!cs_low || st_r != flash_id_pkg::ST_TX) begin
      tx_left_nxt = 7'h00;
      oe_nxt = 4'h0;
      sfdp_addr_nxt = addr_r[7:0];
    end else if (sclk_fall) begin
      oe_nxt = oe_mask;
      if (tx_left_r == 7'h00 && opcode_r == `OPC_PARAM_TABLE) begin
        sfdp_addr_nxt = sfdp_addr_r + 8'h01; // next table byte, wraps at 256
      end
      case (lane)
        flash_id_pkg::LANE_DUAL: begin
          io_nxt = {2'b00, src[63:62]};
          tx_sr_nxt = {src[61:0], 2'b00};
          tx_left_nxt = ((tx_left_r == 7'h00) ? fresh_len : tx_left_r) - 7'h02;
        end
        flash_id_pkg::LANE_QUAD: begin
          io_nxt = src[63:60];
          tx_sr_nxt = {src[59:0], 4'h0};
          tx_left_nxt = ((tx_left_r == 7'h00) ? fresh_len : tx_left_r) - 7'h04;
        end
        default: begin
          io_nxt = {2'b00, src[63], 1'b0}; // serial output line is io[1]
          tx_sr_nxt = {src[62:0], 1'b0};
          tx_left_nxt = ((tx_left_r == 7'h00) ? fresh_len : tx_left_r) - 7'h01;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_sr_r <= 64'h0000_0000_0000_0000;
      tx_left_r <= 7'h00;
      io_r <= 4'h0;
      oe_r <= 4'h0;
      sfdp_addr_r <= 8'h00;
    end else begin
      tx_sr_r <= tx_sr_nxt;
      tx_left_r <= tx_left_nxt;
      io_r <= io_nxt;
      oe_r <= oe_nxt;
      sfdp_addr_r <= sfdp_addr_nxt;
    end
  end
  assign io_o = io_r;
  assign io_oe_o = oe_r;
  assign sfdp_addr_o = sfdp_addr_r;

  // self-timed erase and program engine
  flash_id_pkg::op_state_e op_r, op_nxt;
  logic [23:0] timer_r, timer_nxt;
  logic busy_nxt, latch_clr_r, latch_clr_nxt, erase_req_r, erase_req_nxt;
  logic [1:0] erase_sel_r, erase_sel_nxt;

  always_comb begin
    op_nxt = op_r;
    timer_nxt = timer_r;
    busy_nxt = busy_r;
    latch_clr_nxt = 1'b0;
    erase_req_nxt = 1'b0;
    erase_sel_nxt = erase_sel_r;
    case (op_r)
      flash_id_pkg::OP_IDLE: begin
        if (erase_go) begin
          op_nxt = flash_id_pkg::OP_ERASE;
          timer_nxt = 24'(SEC_ERASE_CYCLES - 1);
          busy_nxt = 1'b1;
          erase_req_nxt = 1'b1;
          erase_sel_nxt = sel_r;
        end else if (prog_go) begin
          op_nxt = flash_id_pkg::OP_PROG;
          timer_nxt = 24'(SEC_PROG_CYCLES - 1);
          busy_nxt = 1'b1;
        end
      end
      flash_id_pkg::OP_ERASE: begin
        if (timer_r == 24'h00_0000) begin
          op_nxt = flash_id_pkg::OP_IDLE;
          busy_nxt = 1'b0;
          latch_clr_nxt = 1'b1;
        end else begin
          timer_nxt = timer_r - 24'h00_0001;
        end
      end
      default: begin
        // a slow array port stretches the cycle until every byte is written
        if (timer_r != 24'h00_0000) begin
          timer_nxt = timer_r - 24'h00_0001;
        end else if (!buf_out_valid) begin
          op_nxt = flash_id_pkg::OP_IDLE;
          busy_nxt = 1'b0;
          latch_clr_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_r <= flash_id_pkg::OP_IDLE;
      timer_r <= 24'h00_0000;
      busy_r <= 1'b0;
      latch_clr_r <= 1'b0;
      erase_req_r <= 1'b0;
      erase_sel_r <= 2'h0;
    end else begin
      op_r <= op_nxt;
      timer_r <= timer_nxt;
      busy_r <= busy_nxt;
      latch_clr_r <= latch_clr_nxt;
      erase_req_r <= erase_req_nxt;
      erase_sel_r <= erase_sel_nxt;
    end
  end
  assign busy_o = busy_r;
  assign write_enable_clear_o = latch_clr_r;
  assign erase_req_o = erase_req_r;
  assign erase_sel_o = erase_sel_r;

endmodule // flash_id_and_security_reg_cmds

`default_nettype wire

// file: testbench/flash_id_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module flash_id_checker #(
  parameter int unsigned SEC_PROG_CYCLES = 10
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic write_enable_latch_i,
  input wire logic [2:0] otp_lock_bits_i,
  input wire logic busy_o,
  input wire logic write_enable_clear_o,
  input wire logic erase_req_o,
  input wire logic [1:0] erase_sel_o,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [1:0] wr_sel_o,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o
);
  logic [31:0] busy_len_r;
  logic [31:0] busy_len_nxt;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // busy length, so a cycle counter cut short is caught
  always_comb begin
    busy_len_nxt = busy_o ? busy_len_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_len_r <= 32'h0;
    end else begin
      busy_len_r <= busy_len_nxt;
    end
  end
  // erase and program requests against latch, locks and select; then busy timing, latch clear and idle outputs
  erase_pulse_a: assert property (erase_req_o |=> !erase_req_o)
    else $error("erase request too long");
  erase_busy_a: assert property (erase_req_o |-> ##[1:2] busy_o)
    else $error("no busy after erase request");
  erase_sel_a: assert property (erase_req_o |-> erase_sel_o inside {2'h1, 2'h2, 2'h3})
    else $error("erase select out of range");
  erase_wel_a: assert property (erase_req_o |-> write_enable_latch_i)
    else $error("erase without write enable");
  erase_lock_a: assert property (erase_req_o |-> !otp_lock_bits_i[erase_sel_o - 2'h1])
    else $error("erase of locked register");
  write_lock_a: assert property (wr_valid_o |-> !otp_lock_bits_i[wr_sel_o - 2'h1])
    else $error("write to locked register");
  write_wel_a: assert property ($rose(wr_valid_o) |-> write_enable_latch_i)
    else $error("write without write enable");
  write_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable({wr_sel_o, wr_addr_o, wr_data_o}))
    else $error("stalled write changed");
  latch_clear_a: assert property (write_enable_clear_o |-> !busy_o && $past(busy_o))
    else $error("latch clear not at busy end");
  busy_len_a: assert property ($fell(busy_o) |-> busy_len_r >= SEC_PROG_CYCLES - 1)
    else $error("busy too short");
  idle_quiet_a: assert property (cs_n_i [*5] |-> io_oe_o == 4'h0)
    else $error("driving while deselected");
  // main scenarios
  cover property (erase_req_o);
  cover property (wr_valid_o && !wr_ready_i);
  cover property (write_enable_clear_o);
  cover property (io_oe_o == 4'hF);
endmodule // flash_id_checker
bind flash_id_and_security_reg_cmds flash_id_checker #(.SEC_PROG_CYCLES(SEC_PROG_CYCLES)) chk_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
  .write_enable_latch_i(write_enable_latch_i), .otp_lock_bits_i(otp_lock_bits_i),
  .busy_o(busy_o), .write_enable_clear_o(write_enable_clear_o), .erase_req_o(erase_req_o),
  .erase_sel_o(erase_sel_o),
  .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_sel_o(wr_sel_o), .wr_addr_o(wr_addr_o),
  .wr_data_o(wr_data_o));
`default_nettype wire

// file: testbench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clock_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_line_o
);
  logic [3:0] host_r = 4'h0;
  // released lines toggle each bit, so a stale value never reads as data
  assign io_line_o = (io_oe_o & io_o) | (~io_oe_o & host_r);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // select; clock stays low between frames
  task automatic start();
    @(negedge clock_i);
    cs_n_o = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  // n clocks of w lanes, 320 ns each: drive at the fall, take at the rise
  task automatic xfer(input int n, input int w, input bit drv, input logic [63:0] dout,
                      output logic [63:0] din);
    logic [3:0] m, nx;
    m = (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hF;
    din = 64'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clock_i);
      sclk_o = 1'b0;
      nx = ~host_r;
      for (int b = 0; b < w; b++) begin
        if (drv) nx[b] = dout[i * w + b];
      end
      host_r = nx; // one update per bit, so the lines never glitch
      repeat (4) @(negedge clock_i);
      sclk_o = 1'b1;
      din = (din << w) | 64'((io_line_o & m) >> (w == 1));
      repeat (3) @(negedge clock_i);
    end
  endtask
  // deselect with no further rise after the last bit
  task automatic stop();
    @(negedge clock_i);
    sclk_o = 1'b0;
    repeat (4) @(negedge clock_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clock_i);
  endtask
endmodule // spi_host_model
`default_nettype wire

// file: testbench/flash_id_and_security_reg_cmds_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_id_and_security_reg_cmds_tb_top;
  localparam logic [7:0] MK = 8'hA7; // arbitrary value
  localparam logic [7:0] DV = 8'h3C; // arbitrary value
  localparam logic [7:0] MT = 8'h41; // arbitrary value
  localparam logic [7:0] CP = 8'h96; // arbitrary value
  localparam logic [63:0] UID = 64'h1F2E_3D4C_5B6A_7988; // arbitrary value
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic we_latch = 1'b0;
  logic [2:0] lock = 3'h0;
  logic wr_ready = 1'b1;
  logic cs_n, sclk, busy_o, write_enable_clear_o, erase_req_o, wr_valid_o, prog_overrun_o;
  logic [3:0] io_line, io_o, io_oe_o;
  logic [1:0] erase_sel_o, wr_sel_o;
  logic [7:0] wr_addr_o, wr_data_o, sfdp_addr_o, sfdp_data;
  logic [17:0] wq[$];
  int erase_cnt = 0;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #20 clock_i = ~clock_i;
  assign sfdp_data = ~sfdp_addr_o;
  spi_host_model h (.clock_i(clock_i), .io_o(io_o), .io_oe_o(io_oe_o), .cs_n_o(cs_n), .sclk_o(sclk),
    .io_line_o(io_line));
  flash_id_and_security_reg_cmds #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEMORY_TYPE_BYTE(MT),
    .CAPACITY_BYTE(CP), .UNIQUE_ID(UID), .SEC_ERASE_CYCLES(20), .SEC_PROG_CYCLES(10)) DUT (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_line),
    .io_o(io_o), .io_oe_o(io_oe_o), .write_enable_latch_i(we_latch), .otp_lock_bits_i(lock),
    .busy_o(busy_o), .write_enable_clear_o(write_enable_clear_o), .erase_req_o(erase_req_o),
    .erase_sel_o(erase_sel_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready), .wr_sel_o(wr_sel_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .sfdp_addr_o(sfdp_addr_o), .sfdp_data_i(sfdp_data),
    .prog_overrun_o(prog_overrun_o));
  // array side: take writes, count erases, latch model; hang guard
  always @(posedge clock_i) begin
    if (wr_valid_o === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_sel_o, wr_addr_o, wr_data_o});
    if (erase_req_o === 1'b1) erase_cnt++;
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end
  always @(negedge clock_i) if (write_enable_clear_o === 1'b1) we_latch <= 1'b0;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one whole frame: opcode, header, optional read
  task automatic cmd(input logic [7:0] op, input int n, input int w, input logic [63:0] v, input int rn,
                     input int rw, output logic [63:0] d);
    h.start();
    h.xfer(8, 1, 1, 64'(op), d);
    h.xfer(n, w, 1, v, d);
    if (rn > 0) h.xfer(rn, rw, 0, 64'h0, d);
    h.stop();
  endtask
  // bounded wait for the self-timed cycle to end
  task automatic wait_idle();
    for (int k = 0; k < 300 && busy_o !== 1'b0; k++) @(negedge clock_i);
    @(negedge clock_i); // let the latch model take the clear pulse first
    chk(64'(busy_o), 64'h0, "busy stuck");
  endtask
  task automatic id_reads();
    logic [63:0] d;
    cmd(8'h9F, 0, 1, 64'h0, 48, 1, d);
    chk(d, {16'h0, MK, MT, CP, MK, MT, CP}, "jedec id");
    cmd(8'h92, 16, 2, 64'hF0, 16, 2, d);
    chk(d, {32'h0, MK, DV, MK, DV}, "dual id");
    cmd(8'h94, 12, 4, 64'hF0, 8, 4, d);
    chk(d, {32'h0, MK, DV, MK, DV}, "quad id");
    cmd(8'h4B, 32, 1, 64'h0, 64, 1, d);
    chk(d, UID, "unique id");
    cmd(8'h5A, 32, 1, 64'hFE00, 24, 1, d);
    chk(d, 64'h0100FF, "table wrap");
  endtask
  task automatic erase_cases();
    logic [63:0] d;
    logic [23:0] bad[6];
    bad = '{24'h002000, 24'h002000, 24'h004000, 24'h012000, 24'h002100, 24'h000000};
    for (int i = 0; i < 6; i++) begin
      we_latch = (i != 0);
      lock = (i == 1) ? 3'h2 : 3'h0;
      cmd(8'h44, 24, 1, 64'(bad[i]), 0, 1, d);
      chk(64'(busy_o), 64'h0, "refused erase busy");
    end
    lock = 3'h0;
    cmd(8'h44, 25, 1, 64'h4000, 0, 1, d);
    chk(64'(erase_cnt), 64'h0, "erase refused");
    cmd(8'h44, 24, 1, 64'h002000, 0, 1, d);
    chk(64'(busy_o), 64'h1, "erase busy");
    wait_idle();
    chk({erase_cnt, 29'h0, erase_sel_o, we_latch}, {32'h1, 29'h0, 2'h2, 1'b0}, "erase done");
  endtask
  task automatic program_cases();
    logic [63:0] d;
    we_latch = 1'b1;
    lock = 3'h4;
    cmd(8'h42, 32, 1, 64'h0030FE5A, 0, 1, d);
    we_latch = 1'b0;
    lock = 3'h0;
    cmd(8'h42, 32, 1, 64'h0030FE5A, 0, 1, d);
    chk({wq.size(), 31'h0, busy_o}, 64'h0, "refused program");
    we_latch = 1'b1;
    wr_ready = 1'b0;
    h.start();
    h.xfer(8, 1, 1, 64'h42, d);
    h.xfer(40, 1, 1, 64'h0030FEA1B2, d);
    repeat (8) @(negedge clock_i);
    chk({wr_valid_o, prog_overrun_o}, 64'h2, "stalled buffer");
    wr_ready = 1'b1;
    h.xfer(12, 1, 1, 64'hC35, d);
    h.stop();
    chk(64'(busy_o), 64'h1, "program busy");
    wait_idle();
    chk({9'h0, we_latch, wq[0], wq[1], wq[2]}, {10'h0, 18'h3FEA1, 18'h3FFB2, 18'h300C3}, "program");
    cmd(8'h4B, 32, 1, 64'h0, 64, 1, d);
    chk(d, UID, "unique id kept");
  endtask
  initial begin
    repeat (5) @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    id_reads();
    erase_cases();
    program_cases();
    finish_test();
  end
endmodule // flash_id_and_security_reg_cmds_tb_top
`default_nettype wire
